/* interval_timer_and_watchdog.sv */
// Interval timer with prescaler, timer interrupt and watchdog behind APB.
// Assumes an APB master on clk_sys_in and a synchronous oscillator tick.
`timescale 1ns/1ps
`default_nettype none
module interval_timer_and_watchdog
  import tmr_wdog_pkg::*;
#(
  parameter int WDOG_TICKS = WDOG_OVF_TICKS
) (
  input  wire logic        clk_sys_in,        // System clock, 100 MHz.
  input  wire logic        resetn_in,         // Asynchronous reset, active low.
  input  wire logic        psel_in,           // APB select.
  input  wire logic        penable_in,        // APB enable.
  input  wire logic        pwrite_in,         // APB direction, 1 is write.
  input  wire logic [11:0] paddr_in,          // APB byte address.
  input  wire logic [31:0] pwdata_in,         // APB write data.
  output logic      [31:0] prdata_out,        // APB read data.
  output logic             pready_out,        // APB ready.
  output logic             pslverr_out,       // APB error on unmapped address.
  input  wire logic        lso_tick_in,       // One pulse per oscillator period.
  input  wire logic        wdog_enable_in,    // Build option: watchdog present.
  input  wire logic        wdog_always_on_in, // Build option: run in low power.
  input  wire logic        low_power_in,      // Green or power-down mode active.
  output logic             tmr_irq_out,       // Timer interrupt, level.
  output logic             green_wake_out,    // Wake pulse on timer overflow.
  output logic             wdog_reset_out     // System reset pulse from watchdog.
);

  logic [7:0] tmr_mode_q;
  logic [7:0] tmr_count_q;
  logic [7:0] pre_q;
  logic       tmr_irq_flag_q;
  logic       tmr_irq_enable_q;
  logic       global_irq_enable_q;
  logic       pready_q;
  logic       pslverr_q;
  logic [31:0] prdata_q;
  logic       irq_q;
  logic       wake_q;
  logic       wdog_reset_q;
  logic       wdog_ovf;

  logic       tmr_run_enable;
  logic [2:0] tmr_prescale_sel;
  logic [7:0] pre_mask;
  logic       tmr_tick;
  logic       tmr_ovf;
  logic [7:0] idx;
  logic       aligned;
  logic       hit_req, hit_en, hit_wdog, hit_mode, hit_count, hit_glb, hit_any;
  logic       access_first;
  logic       commit_wr;
  logic       wr_req, wr_en, wr_wdog, wr_mode, wr_count, wr_glb;
  logic       wdog_clear;
  logic       wdog_run;
  logic [31:0] rdata_d;

  assign tmr_run_enable   = tmr_mode_q[TMR_RUN_BIT];
  assign tmr_prescale_sel = tmr_mode_q[PRESCALE_LSB +: 3];

  // Address decode; the upper address bits must be zero.
  assign idx          = paddr_in[9:2];
  assign aligned      = (paddr_in[1:0] == 2'h0) && (paddr_in[11:10] == 2'h0);
  assign hit_req      = aligned && (idx == IDX_IRQ_REQ);
  assign hit_en       = aligned && (idx == IDX_IRQ_EN);
  assign hit_wdog     = aligned && (idx == IDX_WDOG_CLR);
  assign hit_mode     = aligned && (idx == IDX_TMR_MODE);
  assign hit_count    = aligned && (idx == IDX_TMR_COUNT);
  assign hit_glb      = aligned && (idx == IDX_GLB_CTRL);
  assign hit_any      = hit_req | hit_en | hit_wdog | hit_mode | hit_count | hit_glb;

  // Every access waits one cycle, so a write lands on the pready edge only.
  assign access_first = psel_in && penable_in && !pready_q;
  assign commit_wr    = psel_in && penable_in && pready_q && pwrite_in;
  assign wr_req       = commit_wr && hit_req;
  assign wr_en        = commit_wr && hit_en;
  assign wr_wdog      = commit_wr && hit_wdog;
  assign wr_mode      = commit_wr && hit_mode;
  assign wr_count     = commit_wr && hit_count;
  assign wr_glb       = commit_wr && hit_glb;

  assign pre_mask = PRESCALE_FULL >> tmr_prescale_sel;
  assign tmr_tick = tmr_run_enable && ((pre_q & pre_mask) == pre_mask);
  assign tmr_ovf  = tmr_tick && (tmr_count_q == COUNT_MAX);

  assign wdog_clear = wr_wdog && (pwdata_in[7:0] == WDOG_KEY);
  assign wdog_run   = wdog_enable_in && (!low_power_in || wdog_always_on_in);

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_req) begin
      rdata_d[TMR_IRQ_BIT] = tmr_irq_flag_q;
    end else if (hit_en) begin
      rdata_d[TMR_IRQ_BIT] = tmr_irq_enable_q;
    end else if (hit_mode) begin
      rdata_d[7:0] = tmr_mode_q;
    end else if (hit_count) begin
      rdata_d[7:0] = tmr_count_q;
    end else if (hit_glb) begin
      rdata_d[GLB_IRQ_EN_BIT] = global_irq_enable_q;
    end
  end

  // Read data is latched on the first access cycle, so it stands while pready is high.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access_first;
      pslverr_q <= access_first && !hit_any;
      if (access_first && !pwrite_in) begin
        prdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tmr_mode_q <= MODE_RESET;
    end else if (wr_mode) begin
      tmr_mode_q <= {pwdata_in[7:4], 4'h0};
    end
  end

  // The prescaler restarts while stopped so each run begins on a full step.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_q <= 8'h00;
    end else if (!tmr_run_enable) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // presettable count
  // A preset while running keeps the prescaler phase, so the first step may be short.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tmr_count_q <= COUNT_RESET;
    end else if (wr_count) begin
      tmr_count_q <= pwdata_in[7:0];
    end else if (tmr_tick) begin
      tmr_count_q <= tmr_count_q + 8'h01;
    end
  end

  // overflow sets flag
  // An overflow in the clear cycle keeps the flag, so no event is ever lost.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tmr_irq_flag_q <= 1'b0;
    end else if (tmr_ovf) begin
      tmr_irq_flag_q <= 1'b1;
    end else if (wr_req && pwdata_in[TMR_IRQ_BIT]) begin
      tmr_irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tmr_irq_enable_q    <= 1'b0;
      global_irq_enable_q <= 1'b0;
    end else begin
      if (wr_en) begin
        tmr_irq_enable_q <= pwdata_in[TMR_IRQ_BIT];
      end
      if (wr_glb) begin
        global_irq_enable_q <= pwdata_in[GLB_IRQ_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= tmr_irq_flag_q && tmr_irq_enable_q && global_irq_enable_q;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wake_q       <= 1'b0;
      wdog_reset_q <= 1'b0;
    end else begin
      wake_q       <= tmr_ovf;
      wdog_reset_q <= wdog_ovf;
    end
  end

  wdog_counter #(
    .OVF_TICKS (WDOG_TICKS)
  ) i_wdog_counter (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .tick_in    (lso_tick_in),
    .clear_in   (wdog_clear),
    .run_in     (wdog_run),
    .ovf_out    (wdog_ovf)
  );

  assign prdata_out     = prdata_q;
  assign pready_out     = pready_q;
  assign pslverr_out    = pslverr_q;
  assign tmr_irq_out    = irq_q;
  assign green_wake_out = wake_q;
  assign wdog_reset_out = wdog_reset_q;

  a_tmr_stop_hold: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (!tmr_run_enable && !wr_count) |=> $stable(tmr_count_q) && !wake_q)
    else $error("stopped timer changed count");

  a_tmr_wrap_zero: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (tmr_ovf && !wr_count) |=> tmr_count_q == 8'h00)
    else $error("timer did not wrap to zero");

  a_tmr_flag_set: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    tmr_ovf |=> tmr_irq_flag_q)
    else $error("overflow did not set request flag");

  a_irq_gating: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    ##1 tmr_irq_out == $past(tmr_irq_flag_q && tmr_irq_enable_q && global_irq_enable_q))
    else $error("interrupt output not gated by enables");

  a_prescale_half: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (tmr_tick && tmr_prescale_sel == 3'h7 && !wr_mode) ##1 !wr_mode |-> !tmr_tick ##1 tmr_tick)
    else $error("fastest rate is not half clock");

  a_prescale_slow: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (tmr_tick && tmr_prescale_sel == 3'h0) |-> pre_q == 8'hff)
    else $error("slowest rate is not clock over 256");

  a_count_preset: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    wr_count |=> tmr_count_q == $past(pwdata_in[7:0]))
    else $error("count preset not taken");

  a_count_step: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (tmr_tick && !wr_count) |=> tmr_count_q == $past(tmr_count_q) + 8'h01)
    else $error("count did not advance one step");

  a_flag_clear: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (wr_req && pwdata_in[TMR_IRQ_BIT] && !tmr_ovf) |=> !tmr_irq_flag_q)
    else $error("request flag not cleared by write");

  a_stop_no_flag: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (!tmr_run_enable && !tmr_irq_flag_q) |=> !tmr_irq_flag_q)
    else $error("stopped timer set request flag");

  a_tmr_wake_pulse: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    tmr_ovf |=> green_wake_out ##1 !green_wake_out || $past(tmr_ovf))
    else $error("wake pulse missing after overflow");

  a_wake_cause: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    green_wake_out |-> $past(tmr_ovf))
    else $error("wake pulse without overflow");

  a_irq_quiet: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !global_irq_enable_q |=> !tmr_irq_out)
    else $error("interrupt raised with global enable off");

  a_wdog_bad_key: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (wr_wdog && pwdata_in[7:0] != WDOG_KEY) |-> !wdog_clear)
    else $error("non-key write cleared watchdog");

  a_wdog_gate: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !wdog_run |=> !wdog_ovf)
    else $error("watchdog counted while not running");

  a_wdog_reset_out: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    wdog_ovf |=> wdog_reset_out)
    else $error("watchdog overflow did not reset");

endmodule
`default_nettype wire

/* tmr_wdog_pkg.sv */
// Package for the interval timer and watchdog block.
// Assumes a 32-bit APB master and a single 100 MHz system clock.
package tmr_wdog_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_IRQ_REQ    = 8'hc8;
  localparam logic [7:0] IDX_IRQ_EN     = 8'hc9;
  localparam logic [7:0] IDX_WDOG_CLR   = 8'hcc;
  localparam logic [7:0] IDX_TMR_MODE   = 8'hd8;
  localparam logic [7:0] IDX_TMR_COUNT  = 8'hd9;
  localparam logic [7:0] IDX_GLB_CTRL   = 8'hdf;

  // Field positions.
  localparam int TMR_RUN_BIT    = 7;
  localparam int PRESCALE_LSB   = 4;
  localparam int TMR_IRQ_BIT    = 4;
  localparam int GLB_IRQ_EN_BIT = 7;

  // Values after reset, count limit and full prescaler mask.
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] COUNT_MAX     = 8'hff;
  localparam logic [7:0] PRESCALE_FULL = 8'hff;

  // Watchdog key and overflow length in low-speed oscillator periods.
  localparam logic [7:0] WDOG_KEY       = 8'h5a;
  localparam int         WDOG_OVF_TICKS = 16384;

endpackage

/* wdog_counter.sv */
// Watchdog up counter advanced by low-speed oscillator ticks.
// Assumes tick_in is a one-cycle pulse synchronous to clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module wdog_counter #(
  parameter int OVF_TICKS = 16384
) (
  input  wire logic clk_sys_in,   // System clock.
  input  wire logic resetn_in,    // Asynchronous reset, active low.
  input  wire logic tick_in,      // Oscillator period pulse.
  input  wire logic clear_in,     // Key accepted, restart count.
  input  wire logic run_in,       // Counting allowed.
  output logic      ovf_out       // One-cycle overflow pulse.
);
  localparam int W = $clog2(OVF_TICKS) + 1;
  localparam logic [W-1:0] LAST = W'(OVF_TICKS - 1);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q   <= '0;
      ovf_out <= 1'b0;
    end else begin
      ovf_out <= 1'b0;
      if (clear_in) begin
        cnt_q <= '0;
      end else if (run_in && tick_in) begin
        if (cnt_q == LAST) begin
          cnt_q   <= '0;
          ovf_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  a_wdog_key_clear: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    clear_in |=> cnt_q == '0) else $error("watchdog not cleared by key");

  a_wdog_ovf_len: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (run_in && tick_in && !clear_in && cnt_q == LAST) |=> ovf_out && cnt_q == '0)
    else $error("watchdog overflow at wrong count");

  a_wdog_advances: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (run_in && tick_in && !clear_in && cnt_q != LAST) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("watchdog did not advance");

endmodule
`default_nettype wire

/* tb_interval_timer_and_watchdog.sv */
// Self-checking testbench for the interval timer and watchdog block.
// Assumes the block answers APB with its own ready and takes one tick pulse per oscillator period.
`timescale 1ns/1ps
`default_nettype none
module tb_interval_timer_and_watchdog;
  import tmr_wdog_pkg::*;
  localparam int WD_TICKS = 16;
  logic        clk_sys  = 1'b0;
  logic        resetn   = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lso_tick = 1'b0;
  logic        wd_en    = 1'b1;
  logic        wd_aon   = 1'b0;
  logic        low_pwr  = 1'b0;
  logic        tmr_irq;
  logic        wake;
  logic        wd_rst;
  logic [31:0] rd;
  logic        rerr;
  int          miscompares = 0;
  int          checked     = 0;
  int          wd_pulses   = 0;
  int          base;
  int          n;
  int          exp_n;

  interval_timer_and_watchdog #(.WDOG_TICKS(WD_TICKS)) i_interval_timer_and_watchdog (
    .clk_sys_in(clk_sys), .resetn_in(resetn), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .lso_tick_in(lso_tick),
    .wdog_enable_in(wd_en), .wdog_always_on_in(wd_aon), .low_power_in(low_pwr),
    .tmr_irq_out(tmr_irq), .green_wake_out(wake), .wdog_reset_out(wd_rst));

  always #5 clk_sys = ~clk_sys;

  // Reset pulses are counted so a scenario can compare before and after.
  always @(posedge clk_sys) begin
    if (wd_rst === 1'b1) begin
      wd_pulses <= wd_pulses + 1;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the byte address is four times the register index.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h2, k);
    rd      = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, {24'h0, exp}, rd);
  endtask

  // The gap after each tick lets a reset pulse land and be counted.
  task automatic ticks(input int cnt);
    repeat (cnt) begin
      lso_tick <= 1'b1;
      @(posedge clk_sys);
      lso_tick <= 1'b0;
      repeat (5) @(posedge clk_sys);
    end
  endtask

  task automatic irq_is(input logic exp);
    repeat (3) @(posedge clk_sys);
    chk("irq level", {31'h0, exp}, {31'h0, tmr_irq});
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    miscompares++;
    $display("unexpected timeout expected done seen hang");
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rdc("mode reset", IDX_TMR_MODE, MODE_RESET);
    rdc("count reset", IDX_TMR_COUNT, COUNT_RESET);
    rdc("flag reset", IDX_IRQ_REQ, 8'h00);
    rdc("clear reg read", IDX_WDOG_CLR, 8'h00);
    apb(1'b0, 8'h01, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rd);
    wr(IDX_TMR_COUNT, 8'ha5);
    rdc("count preset", IDX_TMR_COUNT, 8'ha5);
    wr(IDX_TMR_COUNT, COUNT_MAX);
    wr(IDX_TMR_MODE, 8'h7f);
    rdc("mode fields", IDX_TMR_MODE, 8'h70);
    repeat (600) @(posedge clk_sys);
    rdc("stopped count", IDX_TMR_COUNT, COUNT_MAX);
    rdc("stopped flag", IDX_IRQ_REQ, 8'h00);
    wr(IDX_GLB_CTRL, 8'h80);
    for (int s = 0; s < 8; s++) begin
      wr(IDX_TMR_MODE, 8'h00);
      wr(IDX_IRQ_EN, 8'h00);
      wr(IDX_IRQ_REQ, 8'h10);
      wr(IDX_TMR_MODE, {1'b0, s[2:0], 4'h0});
      wr(IDX_TMR_COUNT, 8'hfe);
      wr(IDX_IRQ_EN, {3'b000, s[0], 4'h0});
      wr(IDX_TMR_MODE, {1'b1, s[2:0], 4'h0});
      n = 0;
      exp_n = 2 * (256 >> s);
      while (wake !== 1'b1 && n < 1000) begin
        @(posedge clk_sys);
        n++;
      end
      chk("wake delay", 32'h1, {31'h0, (n >= exp_n && n <= exp_n + 4)});
      rdc("flag set", IDX_IRQ_REQ, 8'h10);
      if (s < 4) begin
        rdc("count wrapped", IDX_TMR_COUNT, 8'h00);
      end
      irq_is(s[0]);
    end
    wr(IDX_TMR_MODE, 8'h00);
    wr(IDX_IRQ_EN, 8'h10);
    irq_is(1'b1);
    wr(IDX_GLB_CTRL, 8'h00);
    irq_is(1'b0);
    wr(IDX_GLB_CTRL, 8'h80);
    wr(IDX_IRQ_REQ, 8'h10);
    irq_is(1'b0);
    wr(IDX_WDOG_CLR, WDOG_KEY);
    base = wd_pulses;
    ticks(WD_TICKS - 1);
    chk("wdog early", 32'h0, wd_pulses - base);
    wr(IDX_WDOG_CLR, 8'h33);
    ticks(1);
    chk("wdog overflow", 32'h1, wd_pulses - base);
    wr(IDX_WDOG_CLR, WDOG_KEY);
    ticks(10);
    wr(IDX_WDOG_CLR, WDOG_KEY);
    ticks(WD_TICKS - 1);
    chk("wdog kept clear", 32'h1, wd_pulses - base);
    wr(IDX_WDOG_CLR, WDOG_KEY);
    low_pwr <= 1'b1;
    ticks(20);
    chk("wdog low power", 32'h1, wd_pulses - base);
    wd_aon <= 1'b1;
    ticks(WD_TICKS);
    chk("wdog always on", 32'h2, wd_pulses - base);
    wd_en   <= 1'b0;
    low_pwr <= 1'b0;
    wr(IDX_WDOG_CLR, WDOG_KEY);
    ticks(20);
    chk("wdog disabled", 32'h2, wd_pulses - base);
    end_sim();
  end
endmodule
`default_nettype wire
